// >>> rtl/tuc_pkg.sv
package tuc_pkg;
  localparam int TUC_UNITS = 10;
  localparam int TUC_DBITS = 7;
  localparam int TUC_SELW = 4;
  // bus map, all offsets chosen for this block
  localparam logic [7:0] TUC_A_CTRL = 8'h00;
  localparam logic [7:0] TUC_A_STAT = 8'h04;
  localparam logic [7:0] TUC_A_RDCH = 8'h08;
  localparam logic [7:0] TUC_A_WRCH = 8'h0C;
  // control register fields
  localparam int TUC_C_READY = 0;
  localparam int TUC_C_DENS = 1;
  localparam int TUC_C_LDPT = 2;
  localparam int TUC_C_UNIT = 4;
  localparam logic [31:0] TUC_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] TUC_RESP_OK = 2'h0;
  localparam logic [1:0] TUC_RESP_SLVERR = 2'h2;
  // echo pulse width
  localparam int TUC_ECHO_NS = 80;
  localparam int TUC_CLK_NS = 40;
  localparam int TUC_ECHO_CYC = (TUC_ECHO_NS + TUC_CLK_NS - 1) / TUC_CLK_NS;
  typedef enum logic [2:0] {
    TUC_IDLE, TUC_READ, TUC_WRITE, TUC_BACK, TUC_REW_LO, TUC_REW_HI
  } tuc_mode_e;
endpackage : tuc_pkg

// >>> rtl/tuc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tuc_sync_if;
  logic [31:0] raw;
  logic [31:0] sync;
  modport src(output raw, input sync);
  modport dst(input raw, output sync);
endinterface : tuc_sync_if
`default_nettype wire

// >>> rtl/tuc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tuc_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lines
  tuc_sync_if.dst s
);
  logic [31:0] meta_ff;
  logic [31:0] sync_ff;
  // two stages per line, first stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 32'h0000_0000;
      sync_ff <= 32'h0000_0000;
    end else begin
      meta_ff <= s.raw;
      sync_ff <= meta_ff;
    end
  end
  assign s.sync = sync_ff;
endmodule : tuc_sync
`default_nettype wire

// >>> rtl/tuc_unit.sv
// Behaviour
// - respond only when the active select line equals own unit-number switch.
// - selected and ready: low or high density ready per density switch.
// - selected, ready and at load point: assert load-point ready.
// - prepare-read command readies reading; report on ready-for-read line.
// - move tape while tape-motion command is held.
// - each read character goes out on seven parallel data lines.
// - prepare-write command readies writing; report on ready-for-write line.
// - on write strobe, load write bus into the write triggers.
// - each write strobe returns one acknowledge (echo) pulse.
// - trigger-release going low clears all write triggers (check character).
// - backward command prepares backspace; then assert ready-for-backward.
// - rewind-call prepares a low-speed rewind.
// - rewind-and-unload prepares a high-speed rewind.
// - assert rewinding response once either rewind has started.
// - indicate-set command sets the tape-indicate trigger.
// - indicate-clear command clears the tape-indicate trigger.
// - while selected, indicate-on response follows the tape-indicate trigger.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tuc_unit
  import tuc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // commands from control unit
  input wire logic [TUC_UNITS-1:0] unit_select,
  input wire logic prepare_read_cmd,
  input wire logic prepare_write_cmd,
  input wire logic tape_motion_cmd,
  input wire logic backward_cmd,
  input wire logic rewind_call_cmd,
  input wire logic rewind_unload_cmd,
  input wire logic indicate_set_cmd,
  input wire logic indicate_clear_cmd,
  input wire logic [TUC_DBITS-1:0] write_bus,
  input wire logic write_strobe,
  input wire logic trigger_release,
  // responses to control unit
  output logic ready_low_density_resp,
  output logic ready_high_density_resp,
  output logic ready_load_point_resp,
  output logic ready_read_resp,
  output logic ready_write_resp,
  output logic ready_backward_resp,
  output logic rewinding_resp,
  output logic indicate_active_resp,
  output logic [TUC_DBITS-1:0] read_data,
  output logic echo_pulse,
  // tape side
  output logic tape_moving,
  output logic [TUC_DBITS-1:0] write_triggers
);
  tuc_sync_if sy ();
  assign sy.raw = {5'h00, trigger_release, write_strobe, write_bus, indicate_clear_cmd, indicate_set_cmd,
                   rewind_unload_cmd, rewind_call_cmd, backward_cmd, tape_motion_cmd, prepare_write_cmd,
                   prepare_read_cmd, unit_select};
  tuc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .s(sy)
  );
  logic [TUC_UNITS-1:0] sel_s;
  logic p_rd, p_wr, go_s, bk_s, rwl_s, rwh_s, tis_s, tic_s, wst_s, trl_s;
  logic [TUC_DBITS-1:0] wb_s;
  assign sel_s = sy.sync[9:0];
  assign p_rd = sy.sync[10];
  assign p_wr = sy.sync[11];
  assign go_s = sy.sync[12];
  assign bk_s = sy.sync[13];
  assign rwl_s = sy.sync[14];
  assign rwh_s = sy.sync[15];
  assign tis_s = sy.sync[16];
  assign tic_s = sy.sync[17];
  assign wb_s = sy.sync[24:18];
  assign wst_s = sy.sync[25];
  assign trl_s = sy.sync[26];

  logic [31:0] ctrl_ff;
  logic [TUC_DBITS-1:0] rdch_ff;
  logic unit_ready, dens_high, at_ldpt;
  logic [TUC_SELW-1:0] unit_num;
  assign unit_ready = ctrl_ff[TUC_C_READY];
  assign dens_high = ctrl_ff[TUC_C_DENS];
  assign at_ldpt = ctrl_ff[TUC_C_LDPT];
  assign unit_num = ctrl_ff[TUC_C_UNIT +: TUC_SELW];

  logic selected;
  always_comb begin
    selected = 1'b0;
    if (unit_num < 4'(TUC_UNITS))
      selected = sel_s[unit_num];
  end

  // mode latched from the commands
  tuc_mode_e mode_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= TUC_IDLE;
    end else if (selected) begin
      if (rwh_s)
        mode_ff <= TUC_REW_HI;
      else if (rwl_s)
        mode_ff <= TUC_REW_LO;
      else if (bk_s)
        mode_ff <= TUC_BACK;
      else if (p_wr)
        mode_ff <= TUC_WRITE;
      else if (p_rd)
        mode_ff <= TUC_READ;
    end
  end

  logic ind_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ind_ff <= 1'b0;
    else if (selected && tis_s)
      ind_ff <= 1'b1;
    else if (selected && tic_s)
      ind_ff <= 1'b0;
  end

  logic wst_d_ff, trl_d_ff;
  logic strobe_rise;
  assign strobe_rise = wst_s && !wst_d_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_d_ff <= 1'b0;
      trl_d_ff <= 1'b0;
      write_triggers <= '0;
    end else begin
      wst_d_ff <= wst_s;
      trl_d_ff <= trl_s;
      if (selected && mode_ff == TUC_WRITE && strobe_rise)
        write_triggers <= wb_s;
      else if (trl_d_ff && !trl_s)
        write_triggers <= '0;
    end
  end

  logic [1:0] echo_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      echo_cnt_ff <= 2'h0;
    else if (selected && mode_ff == TUC_WRITE && strobe_rise)
      echo_cnt_ff <= 2'(TUC_ECHO_CYC);
    else if (echo_cnt_ff != 2'h0)
      echo_cnt_ff <= echo_cnt_ff - 2'h1;
  end

  // responses, gates every one by selection
  logic rdy;
  assign rdy = selected && unit_ready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_low_density_resp <= 1'b0;
      ready_high_density_resp <= 1'b0;
      ready_load_point_resp <= 1'b0;
      ready_read_resp <= 1'b0;
      ready_write_resp <= 1'b0;
      ready_backward_resp <= 1'b0;
      rewinding_resp <= 1'b0;
      indicate_active_resp <= 1'b0;
      read_data <= '0;
      echo_pulse <= 1'b0;
      tape_moving <= 1'b0;
    end else begin
      ready_low_density_resp <= rdy && !dens_high;
      ready_high_density_resp <= rdy && dens_high;
      ready_load_point_resp <= rdy && at_ldpt;
      ready_read_resp <= rdy && mode_ff == TUC_READ;
      ready_write_resp <= rdy && mode_ff == TUC_WRITE;
      ready_backward_resp <= rdy && mode_ff == TUC_BACK;
      rewinding_resp <= selected && (mode_ff == TUC_REW_LO || mode_ff == TUC_REW_HI);
      indicate_active_resp <= selected && ind_ff;
      read_data <= selected ? rdch_ff : '0;
      echo_pulse <= selected && echo_cnt_ff != 2'h0;
      tape_moving <= rdy && go_s;
    end
  end

  // axi4-lite slave
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TUC_RESP_OK;
      ctrl_ff <= TUC_CTRL_RST;
      rdch_ff <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (aw_ff && w_ff) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= TUC_RESP_OK;
        case (awaddr_ff)
          TUC_A_CTRL: begin
            for (int b = 0; b < 4; b++)
              if (wstrb_ff[b])
                ctrl_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
          end
          TUC_A_RDCH: begin
            if (wstrb_ff[0])
              rdch_ff <= wdata_ff[TUC_DBITS-1:0];
          end
          TUC_A_STAT, TUC_A_WRCH: ;
          default: s_axi_bresp <= TUC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TUC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= TUC_RESP_OK;
      case (s_axi_araddr)
        TUC_A_CTRL: s_axi_rdata <= ctrl_ff;
        TUC_A_STAT: s_axi_rdata <= {21'h0, ind_ff, tape_moving, mode_ff, 1'b0, selected, unit_ready, 3'h0};
        TUC_A_RDCH: s_axi_rdata <= {25'h0, rdch_ff};
        TUC_A_WRCH: s_axi_rdata <= {25'h0, write_triggers};
        // unmapped reads flag slverr, same as unmapped writes
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= TUC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // strobe accepted, then the echo stands two cycles
  sequence seq_strobe_taken;
    selected && mode_ff == TUC_WRITE && strobe_rise;
  endsequence
  sequence seq_echo_burst;
    echo_pulse ##1 echo_pulse;
  endsequence

  chk_unsel_silent: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(selected) |-> !(ready_low_density_resp || ready_high_density_resp || rewinding_resp
    || indicate_active_resp)) else $error("response while unselected");
  chk_density_ready: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(rdy) |-> (ready_high_density_resp == $past(dens_high)) && (ready_low_density_resp != $past(dens_high)))
    else $error("density ready wrong");
  chk_load_point: assert property (@(posedge aclk) disable iff (!aresetn)
    ready_load_point_resp |-> $past(at_ldpt) && $past(rdy)) else $error("load point wrong");
  chk_echo_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_strobe_taken |-> ##2 seq_echo_burst) else $error("echo missing");
  chk_trig_load: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_strobe_taken |=> write_triggers == $past(wb_s)) else $error("trig load");
  chk_trig_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (trl_d_ff && !trl_s && !(selected && mode_ff == TUC_WRITE && strobe_rise)) |=> write_triggers == '0)
    else $error("release failed");
  chk_ind_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (selected && tis_s) |=> ind_ff) else $error("indicate not set");
  chk_rewind_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    (selected && mode_ff == TUC_REW_HI) |=> rewinding_resp) else $error("rewind resp missing");
endmodule : tuc_unit
`default_nettype wire

// >>> dv/tuc_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module tuc_ctl_model
  import tuc_pkg::*;
(
  // clock
  input wire logic aclk,
  // select, commands, write path
  output logic [TUC_UNITS-1:0] unit_select,
  output logic [7:0] cmd,
  output logic [TUC_DBITS-1:0] write_bus,
  output logic write_strobe,
  output logic trigger_release
);
  initial begin
    unit_select = '0;
    cmd = 8'h00;
    write_bus = 7'h00;
    write_strobe = 1'b0;
    trigger_release = 1'b1;
  end
  task automatic sel(input int n);
    @(posedge aclk);
    unit_select <= (n < 0) ? '0 : TUC_UNITS'(1) << n;
  endtask : sel
  task automatic set_cmd(input int i, input logic v);
    @(posedge aclk);
    cmd[i] <= v;
  endtask : set_cmd
  // bus held past the sync delay, then scrambled
  task automatic send(input logic [TUC_DBITS-1:0] d);
    @(posedge aclk);
    write_bus <= d;
    write_strobe <= 1'b1;
    @(posedge aclk);
    write_strobe <= 1'b0;
    repeat (5) @(posedge aclk);
    write_bus <= ~d;
  endtask : send
  task automatic release_all();
    @(posedge aclk);
    trigger_release <= 1'b0;
    repeat (4) @(posedge aclk);
    trigger_release <= 1'b1;
  endtask : release_all
endmodule : tuc_ctl_model
`default_nettype wire

// >>> dv/tape_unit_control_interface_test.sv
`timescale 1ns/10ps
`default_nettype none
module tape_unit_control_interface_test;
  import tuc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, echo_pulse, tape_moving;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [TUC_DBITS-1:0] read_data, write_triggers, write_bus;
  logic [TUC_UNITS-1:0] unit_select;
  logic [7:0] cmd;
  logic write_strobe, trigger_release;
  wire [7:0] resp;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int echo_cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  int ci[5] = '{0, 1, 3, 4, 5};
  logic [7:0] er[5] = '{8'h70, 8'h68, 8'h64, 8'h62, 8'h62};

  always #(TUC_CLK_NS / 2) aclk = ~aclk;

  tuc_ctl_model ctl (.aclk(aclk), .unit_select(unit_select), .cmd(cmd), .write_bus(write_bus),
    .write_strobe(write_strobe), .trigger_release(trigger_release));

  tuc_unit uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .unit_select(unit_select), .prepare_read_cmd(cmd[0]),
    .prepare_write_cmd(cmd[1]), .tape_motion_cmd(cmd[2]), .backward_cmd(cmd[3]),
    .rewind_call_cmd(cmd[4]), .rewind_unload_cmd(cmd[5]), .indicate_set_cmd(cmd[6]),
    .indicate_clear_cmd(cmd[7]), .write_bus(write_bus), .write_strobe(write_strobe),
    .trigger_release(trigger_release), .ready_low_density_resp(resp[7]),
    .ready_high_density_resp(resp[6]), .ready_load_point_resp(resp[5]), .ready_read_resp(resp[4]),
    .ready_write_resp(resp[3]), .ready_backward_resp(resp[2]), .rewinding_resp(resp[1]),
    .indicate_active_resp(resp[0]), .read_data(read_data), .echo_pulse(echo_pulse),
    .tape_moving(tape_moving), .write_triggers(write_triggers));

  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // a hung handshake ends here instead of stalling the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (echo_pulse === 1'b1)
      echo_cyc <= echo_cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!(rvalid && rready));
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // commands pass a two-stage sync, so levels are held a few cycles
  task automatic cmd_pulse(input int i);
    ctl.set_cmd(i, 1'b1);
    wt(4);
    ctl.set_cmd(i, 1'b0);
    wt(4);
  endtask : cmd_pulse

  initial begin
    wt(2);
    aresetn <= 1'b1;
    wt(3);
    chk(resp, 8'h00);
    axi_rd(TUC_A_CTRL, d, r);
    chk(d, TUC_CTRL_RST);
    axi_wr(TUC_A_CTRL, 32'h0000_0031, r);
    chk(r, TUC_RESP_OK);
    ctl.sel(5);
    wt(6);
    chk(resp, 8'h00);
    ctl.sel(3);
    wt(6);
    chk(resp, 8'h80);
    axi_wr(TUC_A_CTRL, 32'h0000_0037, r);
    wt(6);
    chk(resp, 8'h60);
    for (int i = 0; i < 5; i++) begin
      cmd_pulse(ci[i]);
      chk(resp, er[i]);
      axi_rd(TUC_A_STAT, d, r);
      chk(d[8:6], i + 1);
    end
    cmd_pulse(0);
    ctl.set_cmd(2, 1'b1);
    wt(6);
    chk(tape_moving, 1'b1);
    ctl.set_cmd(2, 1'b0);
    wt(6);
    chk(tape_moving, 1'b0);
    axi_wr(TUC_A_RDCH, 32'h0000_0055, r);
    wt(3);
    chk(read_data, 7'h55);
    cmd_pulse(1);
    ctl.send(7'h2A);
    chk(write_triggers, 7'h2A);
    ctl.send(7'h55);
    chk(write_triggers, 7'h55);
    axi_rd(TUC_A_WRCH, d, r);
    chk(d[6:0], 7'h55);
    // the echo counter updates on the edge, so look once the read has let it settle
    chk(echo_cyc, 2 * TUC_ECHO_CYC);
    ctl.release_all();
    wt(4);
    chk(write_triggers, 7'h00);
    cmd_pulse(6);
    chk(resp[0], 1'b1);
    cmd_pulse(7);
    chk(resp[0], 1'b0);
    cmd_pulse(6);
    ctl.sel(-1);
    wt(6);
    chk(resp, 8'h00);
    chk(read_data, 7'h00);
    axi_rd(8'h10, d, r);
    chk(r, TUC_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    axi_wr(8'h10, 32'h0000_0001, r);
    chk(r, TUC_RESP_SLVERR);
    finish_test();
  end
endmodule : tape_unit_control_interface_test
`default_nettype wire
